// ### src/uefc_top.sv
// Purpose: Command and status logic of one transmit and one receive endpoint FIFO pair
// Assumes: Single clock, synchronous active-high reset, bus engine events synchronous
// Notes: Registers over classic Wishbone, one-cycle ack; no interrupt logic here
// Operation
// - Transmit discard empties FIFO, idles endpoint, zeroes both pointers.
// - Transmit discard waits for active transmission, then command bit self-clears.
// - Setting packet-complete mark saves the transmit read pointer.
// - Refill restores saved read pointer after transmission ends, then self-clears.
// - Transmit low-level flag only while transmit arm bit is set.
// - Transmit flag when remaining bytes at or below 4, 8 or 16 limit.
// - Iso data sent on next IN with bypass, else on frame LSB match.
// - Firmware writes payload only; engine adds PID and CRC16.
// - Two receive status copies; zero-length status read before SETUP status.
// - Receive byte level reports FIFO bytes, saturating at 15.
// - Packet-end flag after ACKed reception or iso EOP; cleared on read.
// - Toggle status shows DATA PID or frame LSB; cleared on read.
// - Setup-received flag set on SETUP, cleared on status read.
// - Media error flag set on reception fault, cleared on read.
// - Receive arm clears after data packet or OUT stall; firmware rearms.
// - SETUP packets accepted whatever the receive arm bit.
// - SETUP after held SETUP with no other token: data dropped, ACK sent.
// - SETUP refused for any other reason gets no handshake.
// - Setup-ignore bit makes the endpoint disregard every SETUP token.
// - Receive discard empties FIFO, idles, zeroes pointers after reception ends.
// - Receive flag when empty bytes at or below 4, 8 or 16 limit.
//
// Implementation choices: the address map and the Wishbone slave port.
`include "uefc_consts.svh"

module uefc_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire uefc_pkg::uefc_evt_s evt_i,
	output uefc_pkg::uefc_ctl_s ctl_o,
	output logic tx_warn_o,
	output logic rx_warn_o
);

	uefc_pkg::uefc_state_s q;
	uefc_pkg::uefc_state_s d;

	logic req;
	logic wr;
	logic rd;
	logic [7:0] wd;
	logic [6:0] tx_cnt;
	logic [6:0] rx_cnt;
	uefc_pkg::uefc_rxstat_s new_stat;
	logic stat_wr;

	function automatic logic warn_hit(input logic [1:0] lim, input logic [6:0] n);
		logic hit;
		case (lim)
			2'b01: hit = (n <= `UEFC_LIM_4);
			2'b10: hit = (n <= `UEFC_LIM_8);
			2'b11: hit = (n <= `UEFC_LIM_16);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	function automatic logic [3:0] level_cap(input logic [6:0] n);
		logic [6:0] c;
		c = (n > `UEFC_LEVEL_CAP) ? `UEFC_LEVEL_CAP : n;
		return c[3:0];
	endfunction

	always_comb begin
		d = q;
		new_stat = '0;
		stat_wr = 1'b0;
		tx_cnt = q.tx_wp - q.tx_rp;
		rx_cnt = q.rx_wp - q.rx_rp;
		// One-cycle ack; the request is seen once because ack blocks it next cycle
		req = wb_cyc_i & wb_stb_i & ~q.ack;
		wr = req & wb_we_i & wb_sel_i[0];
		rd = req & ~wb_we_i;
		wd = wb_dat_i[7:0];
		d.ack = req;
		d.rdata = `UEFC_RST_BYTE;

		if (rd) begin
			case (wb_adr_i)
				`UEFC_ADR_TX_CMD: begin
					d.rdata = {q.tx_bypass, q.tx_lim, q.tx_refill, q.tx_flush,
						q.tx_toggle, q.tx_last, q.tx_en};
				end
				`UEFC_ADR_RX_STAT: begin
					d.rdata = {q.stat0, level_cap(rx_cnt)};
					// Reading pops the older copy; the second copy moves up
					d.stat0 = q.stat1;
					d.stat1 = '0;
				end
				`UEFC_ADR_RX_CMD: begin
					d.rdata = {1'b0, q.rx_lim, 1'b0, q.rx_flush, q.rx_ign, 1'b0, q.rx_arm};
				end
				`UEFC_ADR_EP_CTL: begin
					d.rdata = {q.stall, 1'b0, q.iso, 5'h00};
				end
				`UEFC_ADR_WARN: begin
					d.rdata = {6'h00, q.rx_warn, q.tx_warn};
				end
				`UEFC_ADR_RX_DATA: begin
					d.rdata = q.rxmem[q.rx_rp[5:0]];
					if (rx_cnt != 7'h00) begin
						d.rx_rp = q.rx_rp + 7'h01;
					end
				end
				default: begin
					d.rdata = `UEFC_RST_BYTE;
				end
			endcase
		end

		if (wr) begin
			case (wb_adr_i)
				`UEFC_ADR_TX_CMD: begin
					d.tx_bypass = wd[`UEFC_TXC_BYPASS];
					d.tx_lim = wd[`UEFC_TXC_LIM_HI:`UEFC_TXC_LIM_LO];
					d.tx_toggle = wd[`UEFC_TXC_TOGGLE];
					d.tx_en = wd[`UEFC_TXC_EN];
					d.tx_last = wd[`UEFC_TXC_LAST];
					// Writing 0 cannot cancel a pending flush or refill
					d.tx_flush = q.tx_flush | wd[`UEFC_TXC_FLUSH];
					d.tx_refill = q.tx_refill | wd[`UEFC_TXC_REFILL];
					if (wd[`UEFC_TXC_LAST] && !q.tx_last) begin
						d.tx_save = q.tx_rp;
					end
				end
				`UEFC_ADR_TX_DATA: begin
					// Payload only; PID and CRC16 are the engine's job
					if (tx_cnt < `UEFC_FIFO_DEPTH) begin
						d.txmem[q.tx_wp[5:0]] = wd;
						d.tx_wp = q.tx_wp + 7'h01;
					end
				end
				`UEFC_ADR_RX_CMD: begin
					d.rx_lim = wd[`UEFC_RXC_LIM_HI:`UEFC_RXC_LIM_LO];
					d.rx_ign = wd[`UEFC_RXC_IGN];
					d.rx_arm = wd[`UEFC_RXC_ARM];
					d.rx_flush = q.rx_flush | wd[`UEFC_RXC_FLUSH];
				end
				`UEFC_ADR_EP_CTL: begin
					d.stall = wd[`UEFC_EPC_STALL];
					d.iso = wd[`UEFC_EPC_ISO];
				end
				default: begin
					d.rdata = `UEFC_RST_BYTE;
				end
			endcase
		end

		// Transmit side; hardware events follow software so the event wins
		if (evt_i.in_token && q.ctl.tx_send && !q.tx_busy) begin
			d.tx_busy = 1'b1;
		end
		if (evt_i.tx_pop && q.tx_busy && tx_cnt != 7'h00) begin
			d.tx_rp = q.tx_rp + 7'h01;
		end
		if (evt_i.tx_end && q.tx_busy) begin
			d.tx_busy = 1'b0;
			d.tx_en = 1'b0;
			d.tx_last = 1'b0;
		end
		if (q.tx_flush && !q.tx_busy) begin
			d.tx_wp = 7'h00;
			d.tx_rp = 7'h00;
			d.tx_en = 1'b0;
			d.tx_last = 1'b0;
			d.tx_flush = 1'b0;
		end else if (q.tx_refill && !q.tx_busy) begin
			d.tx_rp = q.tx_save;
			d.tx_refill = 1'b0;
		end

		// Receive side; IN or OUT breaks a run of back-to-back SETUPs
		if (evt_i.in_token || evt_i.out_token) begin
			d.setup_held = 1'b0;
		end
		if (evt_i.out_token) begin
			if (q.stall) begin
				d.rx_arm = 1'b0;
			end else if (q.rx_arm && !q.rx_busy) begin
				d.rx_busy = 1'b1;
				d.rx_drop = 1'b0;
				d.rx_setup = 1'b0;
			end
		end
		if (evt_i.setup_token) begin
			case (q.ctl.setup_ans)
				uefc_pkg::SET_ACCEPT: begin
					d.rx_busy = 1'b1;
					d.rx_drop = 1'b0;
					d.rx_setup = 1'b1;
				end
				uefc_pkg::SET_DROP: begin
					d.rx_busy = 1'b1;
					d.rx_drop = 1'b1;
					d.rx_setup = 1'b1;
				end
				default: begin
					d.rx_setup = q.rx_setup;
				end
			endcase
		end
		if (evt_i.rx_push && q.rx_busy && !q.rx_drop && rx_cnt < `UEFC_FIFO_DEPTH) begin
			d.rxmem[q.rx_wp[5:0]] = evt_i.rx_data;
			d.rx_wp = q.rx_wp + 7'h01;
		end
		if (evt_i.rx_end && q.rx_busy) begin
			d.rx_busy = 1'b0;
			if (!q.rx_drop) begin
				stat_wr = 1'b1;
				new_stat.last = 1'b1;
				new_stat.setup = q.rx_setup;
				new_stat.toggle = q.iso ? evt_i.frame_lsb : evt_i.rx_pid1;
				if (q.rx_setup) begin
					d.setup_held = 1'b1;
				end else begin
					d.rx_arm = 1'b0;
				end
			end
		end else if (evt_i.rx_err && q.rx_busy) begin
			// Firmware must discard the FIFO after seeing the error
			d.rx_busy = 1'b0;
			stat_wr = 1'b1;
			new_stat.err = 1'b1;
		end
		if (stat_wr) begin
			if (d.stat0 == '0) begin
				d.stat0 = new_stat;
			end else begin
				d.stat1 = d.stat1 | new_stat;
			end
		end
		if (q.rx_flush && !q.rx_busy) begin
			d.rx_wp = 7'h00;
			d.rx_rp = 7'h00;
			d.rx_arm = 1'b0;
			d.setup_held = 1'b0;
			d.rx_flush = 1'b0;
		end

		// Registered answers to the engine, from next state
		d.ctl.tx_send = d.tx_en & ~d.stall & ~d.tx_busy &
			(~d.iso | d.tx_bypass | (evt_i.frame_lsb == d.tx_toggle));
		d.ctl.tx_pid1 = d.tx_toggle & ~d.iso;
		d.ctl.tx_data = d.txmem[d.tx_rp[5:0]];
		d.ctl.rx_ok = d.rx_arm & ~d.rx_busy & ~d.stall;
		if (d.rx_ign) begin
			d.ctl.setup_ans = uefc_pkg::SET_IGNORE;
		end else if (d.setup_held && !d.rx_busy) begin
			d.ctl.setup_ans = uefc_pkg::SET_DROP;
		end else if (!d.rx_busy && d.stat1 == '0 && !d.rx_flush) begin
			d.ctl.setup_ans = uefc_pkg::SET_ACCEPT;
		end else begin
			d.ctl.setup_ans = uefc_pkg::SET_REFUSE;
		end
		// Filling before arming raises no warning
		d.tx_warn = d.tx_en & warn_hit(d.tx_lim, d.tx_wp - d.tx_rp);
		d.rx_warn = warn_hit(d.rx_lim, `UEFC_FIFO_DEPTH - (d.rx_wp - d.rx_rp));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o = {24'h00_0000, q.rdata};
	assign wb_ack_o = q.ack;
	assign ctl_o = q.ctl;
	assign tx_warn_o = q.tx_warn;
	assign rx_warn_o = q.rx_warn;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic stat_rd;
	assign stat_rd = rd && wb_adr_i == `UEFC_ADR_RX_STAT;

	chk_tx_flush_done: assert property (
		q.tx_flush && !q.tx_busy |=> q.tx_wp == 7'h00 && q.tx_rp == 7'h00 && !q.tx_en
	) else $error("transmit discard did not empty the FIFO");

	chk_tx_flush_defer: assert property (
		q.tx_flush && q.tx_busy && !evt_i.tx_end |=> q.tx_flush && q.tx_busy
	) else $error("transmit discard ran during transmission");

	chk_last_save: assert property (
		wr && wb_adr_i == `UEFC_ADR_TX_CMD && wd[`UEFC_TXC_LAST] && !q.tx_last
		|=> q.tx_save == $past(q.tx_rp)
	) else $error("read pointer not saved on packet-complete mark");

	chk_refill_load: assert property (
		q.tx_refill && !q.tx_busy && !q.tx_flush
		|=> q.tx_rp == $past(q.tx_save) && !q.tx_refill
	) else $error("refill did not restore the read pointer");

	chk_tx_warn_arm: assert property (
		!q.tx_en |-> !q.tx_warn
	) else $error("transmit warning while not armed");

	chk_rx_level_sat: assert property (
		stat_rd |=> wb_ack_o && wb_dat_o[3:0] == level_cap($past(rx_cnt))
	) else $error("receive byte level wrong");

	chk_status_pop: assert property (
		stat_rd && !evt_i.rx_end && !evt_i.rx_err |=> q.stat0 == $past(q.stat1)
	) else $error("status read did not shift the copies");

	chk_status_keep: assert property (
		!stat_rd && q.stat0 != '0 |=> q.stat0 != '0
	) else $error("status lost without a read");

	chk_setup_ignore: assert property (
		q.rx_ign && evt_i.setup_token && !q.rx_busy |=> !q.rx_busy
	) else $error("ignored SETUP started a reception");

	chk_rx_arm_clear: assert property (
		evt_i.rx_end && q.rx_busy && !q.rx_setup && !q.rx_drop |=> !q.rx_arm
	) else $error("receive arm not cleared after data packet");

	chk_dup_drop: assert property (
		q.rx_busy && q.rx_drop && evt_i.rx_push |=> $stable(q.rx_wp)
	) else $error("duplicate SETUP data was stored");

	chk_rx_flush: assert property (
		q.rx_flush && q.rx_busy && !evt_i.rx_end && !evt_i.rx_err |=> q.rx_flush
	) else $error("receive discard ran during reception");

	chk_rx_flush_done: assert property (
		q.rx_flush && !q.rx_busy |=> q.rx_wp == 7'h00 && q.rx_rp == 7'h00 && !q.rx_flush
	) else $error("receive discard did not empty the FIFO");

	chk_iso_lock: assert property (
		q.ctl.tx_send && q.iso && !q.tx_bypass |-> q.tx_toggle == $past(evt_i.frame_lsb)
	) else $error("isochronous data released outside its frame");

	chk_second_copy: assert property (
		q.stat0 != '0 && !stat_rd && evt_i.rx_end && q.rx_busy && !q.rx_drop
		|=> q.stat0 == $past(q.stat0) && q.stat1.last
	) else $error("second status copy not filled");

	chk_rx_last_flag: assert property (
		evt_i.rx_end && q.rx_busy && !q.rx_drop |=> q.stat0.last || q.stat1.last
	) else $error("packet-end flag not set");

	chk_err_flag: assert property (
		evt_i.rx_err && !evt_i.rx_end && q.rx_busy |=> q.stat0.err || q.stat1.err
	) else $error("media error flag not set");

	chk_tx_warn_lim: assert property (
		q.tx_en && q.tx_lim == 2'b11 |-> q.tx_warn == ((q.tx_wp - q.tx_rp) <= `UEFC_LIM_16)
	) else $error("transmit warning disagrees with limit");

	chk_setup_accept: assert property (
		evt_i.setup_token && q.ctl.setup_ans == uefc_pkg::SET_ACCEPT
		|=> q.rx_busy && q.rx_setup
	) else $error("accepted SETUP did not start a reception");

	cov_flush_defer: cover property (q.tx_flush && q.tx_busy ##[1:100] !q.tx_flush);
	cov_dup_setup: cover property (q.ctl.setup_ans == uefc_pkg::SET_DROP && evt_i.setup_token);
	cov_two_copies: cover property (q.stat0 != '0 && q.stat1 != '0);
	cov_refill: cover property (q.tx_refill ##1 !q.tx_refill);
	cov_setup_refused: cover property (q.ctl.setup_ans == uefc_pkg::SET_REFUSE && q.rx_busy);

endmodule

// ### src/uefc_consts.svh
// Purpose: Offsets, field positions, reset values and limits of the endpoint FIFO block
// Assumes: Byte addresses on a 32-bit classic Wishbone, one register per aligned word
// Notes: Register data sits in bits 7:0; upper bits read as zero
`ifndef UEFC_CONSTS_SVH
`define UEFC_CONSTS_SVH

`define UEFC_ADR_TX_CMD 8'h00
`define UEFC_ADR_TX_DATA 8'h04
`define UEFC_ADR_RX_STAT 8'h08
`define UEFC_ADR_RX_CMD 8'h0C
`define UEFC_ADR_EP_CTL 8'h10
`define UEFC_ADR_WARN 8'h14
`define UEFC_ADR_RX_DATA 8'h18

`define UEFC_TXC_BYPASS 7
`define UEFC_TXC_LIM_HI 6
`define UEFC_TXC_LIM_LO 5
`define UEFC_TXC_REFILL 4
`define UEFC_TXC_FLUSH 3
`define UEFC_TXC_TOGGLE 2
`define UEFC_TXC_LAST 1
`define UEFC_TXC_EN 0

`define UEFC_RXC_LIM_HI 6
`define UEFC_RXC_LIM_LO 5
`define UEFC_RXC_FLUSH 3
`define UEFC_RXC_IGN 2
`define UEFC_RXC_ARM 0

`define UEFC_EPC_STALL 7
`define UEFC_EPC_ISO 5

`define UEFC_WARN_TX 0
`define UEFC_WARN_RX 1

`define UEFC_RST_BYTE 8'h00
`define UEFC_FIFO_DEPTH 7'h40
`define UEFC_LEVEL_CAP 7'h0f
`define UEFC_LIM_4 7'h04
`define UEFC_LIM_8 7'h08
`define UEFC_LIM_16 7'h10

`endif

// ### src/uefc_pkg.sv
// Purpose: Types shared by the endpoint FIFO block and its users
// Assumes: Constants come from uefc_consts.svh
// Notes: The whole module state is one packed struct
`include "uefc_consts.svh"

package uefc_pkg;

	typedef enum logic [1:0] {
		SET_IGNORE,
		SET_ACCEPT,
		SET_DROP,
		SET_REFUSE
	} uefc_setup_e;

	// Events from the bus engine, each a one-cycle pulse except frame_lsb and the rx_data and rx_pid1 values
	typedef struct packed {
		logic in_token;
		logic out_token;
		logic setup_token;
		logic tx_pop;
		logic tx_end;
		logic rx_push;
		logic [7:0] rx_data;
		logic rx_end;
		logic rx_pid1;
		logic rx_err;
		logic frame_lsb;
	} uefc_evt_s;

	// Answers to the bus engine
	typedef struct packed {
		logic tx_send;
		logic tx_pid1;
		logic [7:0] tx_data;
		logic rx_ok;
		uefc_setup_e setup_ans;
	} uefc_ctl_s;

	// Receive status copy: error, setup, toggle, packet end
	typedef struct packed {
		logic err;
		logic setup;
		logic toggle;
		logic last;
	} uefc_rxstat_s;

	typedef struct packed {
		logic [63:0][7:0] txmem;
		logic [63:0][7:0] rxmem;
		logic [6:0] tx_wp;
		logic [6:0] tx_rp;
		logic [6:0] tx_save;
		logic [6:0] rx_wp;
		logic [6:0] rx_rp;
		logic tx_en;
		logic tx_last;
		logic tx_toggle;
		logic tx_flush;
		logic tx_refill;
		logic tx_bypass;
		logic [1:0] tx_lim;
		logic rx_arm;
		logic rx_flush;
		logic rx_ign;
		logic [1:0] rx_lim;
		logic stall;
		logic iso;
		logic tx_busy;
		logic rx_busy;
		logic rx_drop;
		logic rx_setup;
		logic setup_held;
		uefc_rxstat_s stat0;
		uefc_rxstat_s stat1;
		logic ack;
		logic [7:0] rdata;
		logic tx_warn;
		logic rx_warn;
		uefc_ctl_s ctl;
	} uefc_state_s;

endpackage

// ### dv/uefc_eng_model.sv
// Purpose: Bus engine stand-in raising token, byte and packet-end events
// Assumes: Events launch just after a rising edge and last one cycle
// Notes: Idle data lines show the inverse of their last value, never a stale copy
module uefc_eng_model (
	input wire logic clk_i,
	output uefc_pkg::uefc_evt_s evt_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial evt_o = '0;

	function automatic uefc_pkg::uefc_evt_s quiet(input uefc_pkg::uefc_evt_s e);
		quiet = '0;
		quiet.rx_data = ~e.rx_data;
		quiet.rx_pid1 = ~e.rx_pid1;
		quiet.frame_lsb = e.frame_lsb;
	endfunction

	task automatic tok(input int kind);
		@(posedge clk_i);
		evt_o.in_token <= kind == 0;
		evt_o.out_token <= kind == 1;
		evt_o.setup_token <= kind == 2;
		@(posedge clk_i);
		evt_o <= quiet(evt_o);
	endtask

	// Payload only: the handshake and checksum never reach the FIFO
	task automatic push(input logic [7:0] d);
		@(posedge clk_i);
		evt_o.rx_push <= 1'b1;
		evt_o.rx_data <= d;
		@(posedge clk_i);
		evt_o <= quiet(evt_o);
	endtask

	task automatic fin(input logic p, input logic e);
		@(posedge clk_i);
		evt_o.rx_end <= !e;
		evt_o.rx_err <= e;
		evt_o.rx_pid1 <= p;
		@(posedge clk_i);
		evt_o <= quiet(evt_o);
	endtask

	// Spacing of two cycles comes from the trailing edge of each call
	task automatic pop();
		@(posedge clk_i);
		evt_o.tx_pop <= 1'b1;
		@(posedge clk_i);
		evt_o <= quiet(evt_o);
	endtask

	task automatic tend();
		@(posedge clk_i);
		evt_o.tx_end <= 1'b1;
		@(posedge clk_i);
		evt_o <= quiet(evt_o);
	endtask

	task automatic lsb(input logic b);
		@(posedge clk_i);
		evt_o.frame_lsb <= b;
	endtask
endmodule

// ### dv/tb.sv
// Purpose: Self-checking bench for the endpoint FIFO command and status block
// Assumes: One-cycle Wishbone ack; the engine model drives the event port
// Notes: Random bytes, limits and toggles come from a fixed seed
`include "uefc_consts.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, tx_warn_o, rx_warn_o, p;
	logic [7:0] b0;
	uefc_pkg::uefc_evt_s evt;
	uefc_pkg::uefc_ctl_s ctl;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int k, lim;
	logic [7:0] adrs [5] = '{`UEFC_ADR_TX_CMD, `UEFC_ADR_TX_DATA, `UEFC_ADR_RX_STAT,
		`UEFC_ADR_RX_CMD, 8'h20};

	always #4 clk_i = ~clk_i;

	uefc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt_i(evt), .ctl_o(ctl),
		.tx_warn_o(tx_warn_o), .rx_warn_o(rx_warn_o));
	uefc_eng_model eng (.clk_i(clk_i), .evt_o(evt));

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			wrap_up;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until ack is sampled; only the global timeout ends a stuck wait
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
		input logic s = 1'b1);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= {3'($urandom), s};
		wb_dat_i <= {24'($urandom), d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic w2;
		repeat (2) @(posedge clk_i);
	endtask

	function automatic logic [31:0] st(input logic e, s, t, l, input int n);
		return {24'h00_0000, e, s, t, l, 4'(n > 15 ? 15 : n)};
	endfunction

	// Disabled limit maps to -1 so no byte count can reach it
	function automatic int lv(input int l);
		return l == 0 ? -1 : 4 << (l - 1);
	endfunction

	initial begin
		void'($urandom(32'hee2b));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1, 8'h20, 8'hff);
		wb(1, `UEFC_ADR_TX_CMD, 8'h80, 1'b0);
		foreach (adrs[i]) begin
			wb(0, adrs[i], 8'h00);
			chk(rd, 32'h0000_0000);
		end
		for (lim = 0; lim < 4; lim++) begin
			for (k = 0; k < 2; k++) begin
				wb(1, `UEFC_ADR_TX_CMD, 8'h08);
				repeat (lim == 0 ? k : lv(lim) + k) wb(1, `UEFC_ADR_TX_DATA, 8'($urandom));
				wb(1, `UEFC_ADR_TX_CMD, 8'(lim << 5));
				w2;
				chk(tx_warn_o, 1'b0);
				wb(1, `UEFC_ADR_TX_CMD, 8'(lim << 5 | 3));
				w2;
				chk(tx_warn_o, lim != 0 && k == 0);
			end
		end
		wb(1, `UEFC_ADR_TX_CMD, 8'h08);
		b0 = 8'($urandom);
		wb(1, `UEFC_ADR_TX_DATA, b0);
		wb(1, `UEFC_ADR_TX_DATA, ~b0);
		wb(1, `UEFC_ADR_TX_CMD, 8'h03);
		w2;
		chk(ctl.tx_data, b0);
		eng.tok(0);
		eng.pop();
		w2;
		chk(ctl.tx_data, 8'(~b0));
		wb(1, `UEFC_ADR_TX_CMD, 8'h13);
		wb(0, `UEFC_ADR_TX_CMD, 8'h00);
		chk(rd[4], 1'b1);
		eng.tend();
		w2;
		chk(ctl.tx_data, b0);
		wb(0, `UEFC_ADR_TX_CMD, 8'h00);
		chk(rd[4], 1'b0);
		wb(1, `UEFC_ADR_TX_CMD, 8'h03);
		w2;
		eng.tok(0);
		wb(1, `UEFC_ADR_TX_CMD, 8'h0b);
		wb(0, `UEFC_ADR_TX_CMD, 8'h00);
		chk(rd[3], 1'b1);
		eng.tend();
		w2;
		wb(0, `UEFC_ADR_TX_CMD, 8'h00);
		chk(rd[3], 1'b0);
		wb(1, `UEFC_ADR_TX_DATA, ~b0);
		w2;
		chk(ctl.tx_data, 8'(~b0));
		wb(1, `UEFC_ADR_EP_CTL, 8'h20);
		eng.lsb(1'b0);
		wb(1, `UEFC_ADR_TX_CMD, 8'h07);
		w2;
		chk(ctl.tx_send, 1'b0);
		chk(ctl.tx_pid1, 1'b0);
		eng.lsb(1'b1);
		w2;
		chk(ctl.tx_send, 1'b1);
		eng.lsb(1'b0);
		wb(1, `UEFC_ADR_TX_CMD, 8'h87);
		w2;
		chk(ctl.tx_send, 1'b1);
		wb(1, `UEFC_ADR_EP_CTL, 8'h00);
		chk(ctl.tx_pid1, 1'b1);
		wb(1, `UEFC_ADR_TX_CMD, 8'h08);
		for (int i = 0; i < 6; i++) begin
			k = (i == 0) ? 16 : $urandom_range(63, 0);
			lim = $urandom_range(3, 0);
			p = 1'($urandom);
			wb(1, `UEFC_ADR_RX_CMD, 8'(lim << 5 | 1));
			w2;
			chk(ctl.rx_ok, 1'b1);
			eng.tok(1);
			repeat (k) eng.push(8'($urandom));
			eng.fin(p, 1'b0);
			w2;
			chk(ctl.rx_ok, 1'b0);
			chk(rx_warn_o, 64 - k <= lv(lim));
			wb(0, `UEFC_ADR_WARN, 8'h00);
			chk(rd[1], 64 - k <= lv(lim));
			wb(0, `UEFC_ADR_RX_STAT, 8'h00);
			chk(rd, st(0, 0, p, 1, k));
			wb(0, `UEFC_ADR_RX_STAT, 8'h00);
			chk(rd, st(0, 0, 0, 0, k));
			wb(1, `UEFC_ADR_RX_CMD, 8'h08);
			wb(0, `UEFC_ADR_RX_STAT, 8'h00);
			chk(rd, 32'h0000_0000);
		end
		wb(1, `UEFC_ADR_RX_CMD, 8'h01);
		eng.tok(1);
		repeat (3) eng.push(8'h5a);
		wb(1, `UEFC_ADR_RX_CMD, 8'h09);
		wb(0, `UEFC_ADR_RX_STAT, 8'h00);
		chk(rd, 32'h0000_0003);
		eng.fin(1'b0, 1'b1);
		w2;
		wb(0, `UEFC_ADR_RX_STAT, 8'h00);
		chk(rd & 32'h0000_008f, 32'h0000_0080);
		wb(1, `UEFC_ADR_RX_CMD, 8'h08);
		// The discard leaves the endpoint idle and unarmed, so firmware rearms
		wb(1, `UEFC_ADR_RX_CMD, 8'h01);
		eng.tok(1);
		w2;
		chk(ctl.setup_ans, uefc_pkg::SET_REFUSE);
		eng.fin(1'b1, 1'b0);
		w2;
		chk(ctl.setup_ans, uefc_pkg::SET_ACCEPT);
		eng.tok(2);
		repeat (8) eng.push(8'h11);
		eng.fin(1'b0, 1'b0);
		w2;
		chk(ctl.setup_ans, uefc_pkg::SET_DROP);
		wb(0, `UEFC_ADR_RX_STAT, 8'h00);
		chk(rd, st(0, 0, 1, 1, 8));
		w2;
		chk(ctl.setup_ans, uefc_pkg::SET_DROP);
		eng.tok(2);
		repeat (2) eng.push(8'h22);
		eng.fin(1'b0, 1'b0);
		w2;
		wb(0, `UEFC_ADR_RX_STAT, 8'h00);
		chk(rd & 32'h0000_004f, 32'h0000_0048);
		wb(0, `UEFC_ADR_RX_STAT, 8'h00);
		chk(rd, st(0, 0, 0, 0, 8));
		wb(1, `UEFC_ADR_RX_CMD, 8'h0c);
		w2;
		chk(ctl.setup_ans, uefc_pkg::SET_IGNORE);
		eng.tok(2);
		wb(1, `UEFC_ADR_RX_CMD, 8'h00);
		w2;
		chk(ctl.setup_ans, uefc_pkg::SET_ACCEPT);
		wb(1, `UEFC_ADR_TX_CMD, 8'h80);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, `UEFC_ADR_TX_CMD, 8'h00);
		chk(rd, 32'h0000_0000);
		chk(ctl.setup_ans, uefc_pkg::SET_ACCEPT);
		wrap_up;
	end
endmodule
